// >>> src/reset_state_distribution.sv
// Reset cause decoder and per-register reset value distribution.
`timescale 1ns/10ps

module reset_state_distribution
  import reset_state_pkg::*;
#(
  parameter int NREGS = NUM_REGS,
  parameter int RW = REG_WIDTH,
  // Per-register values and actions for each cause (power-on, undervolt,
  // run watchdog, sleep watchdog).
  parameter logic [NREGS*RW-1:0] VAL_POR = '0,
  parameter logic [NREGS*RW-1:0] VAL_UV = '0,
  parameter logic [NREGS*RW-1:0] VAL_WR = '0,
  parameter logic [NREGS*RW-1:0] VAL_WS = '0,
  parameter logic [NREGS*2-1:0] ACT_POR = {NREGS{2'h1}},
  parameter logic [NREGS*2-1:0] ACT_UV = {NREGS{2'h1}},
  parameter logic [NREGS*2-1:0] ACT_WR = {NREGS{2'h1}},
  parameter logic [NREGS*2-1:0] ACT_WS = {NREGS{2'h0}},
  // Mask of implemented bits; others always read zero.
  parameter logic [NREGS*RW-1:0] IMPL_MASK = '1
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Reset sources, one-cycle requests synchronous to the clock, and the low-power mode level.
  input wire logic power_on_i,
  input wire logic undervoltage_reset_i,
  input wire logic watchdog_timer_timeout_i,
  input wire logic low_power_mode_i,
  // Register write port used in normal running.
  input wire logic [NREGS-1:0] reg_we_i,
  input wire logic [RW-1:0] reg_wdata_i,
  // Status flag updates from the core (halt sets/clears power_down_flag).
  input wire logic flags_we_i,
  input wire status_flags_s flags_wdata_i,
  // Outputs.
  output reset_cause_e cause_o,
  output status_flags_s flags_o,
  output reset_cmd_s cmd_o,
  output logic clear_pc_sp_o,
  output logic [NREGS*RW-1:0] regs_o
);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  initial
  begin
    if (NREGS < 1 || RW < 1)
    begin
      $error("reset_state_distribution: NREGS and RW must be positive");
    end
  end

  // --------------------------------------------------------------------------
  // Cause selection
  // --------------------------------------------------------------------------
  reset_cause_e next_cause;
  reset_cause_e cause;

  // Priority: power-on beats undervoltage beats watchdog, since a supply
  // collapse makes any watchdog event meaningless.
  always_comb
  begin
    next_cause = CAUSE_NONE;
    if (power_on_i)
    begin
      next_cause = CAUSE_POWER_ON;
    end
    else if (undervoltage_reset_i && !low_power_mode_i)
    begin
      // Undervoltage detection is off in idle or sleep mode.
      next_cause = CAUSE_UNDERVOLT;
    end
    else if (watchdog_timer_timeout_i && low_power_mode_i)
    begin
      next_cause = CAUSE_WDT_SLEEP;
    end
    else if (watchdog_timer_timeout_i)
    begin
      next_cause = CAUSE_WDT_RUN;
    end
  end

  // Registered one-hot selector, one clock after the request. [R12]
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cause <= CAUSE_POWER_ON;
    end
    else
    begin
      cause <= next_cause; // [R12]
    end
  end

  assign cause_o = cause;

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  status_flags_s flags;

  // Reset causes override a core write in the same cycle.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      flags <= '0;
    end
    else
    begin
      case (cause)
        CAUSE_POWER_ON:
        begin
          flags.timeout_flag <= FLAG_CLEAR; // [R2]
          flags.power_down_flag <= FLAG_CLEAR; // [R2]
        end
        CAUSE_UNDERVOLT:
        begin
          flags <= flags; // [R3]
        end
        CAUSE_WDT_RUN:
        begin
          flags.timeout_flag <= FLAG_SET; // [R4]
        end
        CAUSE_WDT_SLEEP:
        begin
          flags.timeout_flag <= FLAG_SET; // [R1]
          flags.power_down_flag <= FLAG_SET; // [R1]
        end
        CAUSE_NONE:
        begin
          if (flags_we_i)
          begin
            flags <= flags_wdata_i;
          end
        end
        default:
        begin
          flags <= flags;
        end
      endcase
    end
  end

  assign flags_o = flags;

  // --------------------------------------------------------------------------
  // Core and peripheral commands
  // --------------------------------------------------------------------------
  reset_cmd_s cmd;

  // Commands are registered pulses lasting the cycle after the cause.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd <= '0;
      clear_pc_sp_o <= 1'b0;
    end
    else
    begin
      cmd <= '0;
      clear_pc_sp_o <= 1'b0;
      case (cause)
        CAUSE_POWER_ON, CAUSE_UNDERVOLT, CAUSE_WDT_RUN:
        begin
          cmd.clear_pc <= 1'b1; // [R5]
          cmd.init_stack <= 1'b1; // [R10]
          cmd.clear_int_enables <= 1'b1; // [R6]
          cmd.clear_wdt_timebase <= 1'b1; // [R7]
          cmd.timers_off <= 1'b1; // [R8]
          cmd.ports_input <= 1'b1; // [R9]
        end
        CAUSE_WDT_SLEEP:
        begin
          clear_pc_sp_o <= 1'b1; // [R1]
        end
        default:
        begin
          cmd <= '0;
        end
      endcase
    end
  end

  assign cmd_o = cmd;

  // --------------------------------------------------------------------------
  // Per-register reset values
  // --------------------------------------------------------------------------
  // Selects the action for register index i under the current cause.
  function automatic logic [1:0] act_of(input reset_cause_e c, input int i);
    logic [1:0] a;
    a = ACT_KEEP;
    case (c)
      CAUSE_POWER_ON: a = ACT_POR[i*2 +: 2];
      CAUSE_UNDERVOLT: a = ACT_UV[i*2 +: 2];
      CAUSE_WDT_RUN: a = ACT_WR[i*2 +: 2];
      CAUSE_WDT_SLEEP: a = ACT_WS[i*2 +: 2];
      default: a = ACT_KEEP;
    endcase
    return a;
  endfunction : act_of

  // Selects the load value for register index i under the current cause.
  function automatic logic [RW-1:0] val_of(input reset_cause_e c,
    input int i);
    logic [RW-1:0] v;
    v = '0;
    case (c)
      CAUSE_POWER_ON: v = VAL_POR[i*RW +: RW];
      CAUSE_UNDERVOLT: v = VAL_UV[i*RW +: RW];
      CAUSE_WDT_RUN: v = VAL_WR[i*RW +: RW];
      CAUSE_WDT_SLEEP: v = VAL_WS[i*RW +: RW];
      default: v = '0;
    endcase
    return v;
  endfunction : val_of

  // Unknown values are modelled as zero; software must not rely on them.
  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++)
    begin : g_reg
      logic [RW-1:0] value;
      always_ff @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          value <= '0;
        end
        else if (cause != CAUSE_NONE)
        begin
          case (act_of(cause, gi))
            ACT_LOAD: value <= val_of(cause, gi) & IMPL_MASK[gi*RW +: RW]; // [R11]
            ACT_UNKNOWN: value <= '0; // [R11]
            default: value <= value; // [R11]
          endcase
        end
        else if (reg_we_i[gi])
        begin
          value <= reg_wdata_i & IMPL_MASK[gi*RW +: RW]; // [R11]
        end
      end
      assign regs_o[gi*RW +: RW] = value;
    end
  endgenerate

endmodule : reset_state_distribution

// >>> src/reset_state_pkg.sv
// Package with constants and types for the reset state distribution block.
// ----------------------------------------------------------------------------
// Overview of operation
// (R1) Sleep/idle watchdog reset: clear PC and stack pointer, set both flags.
// (R2) Power-on reset clears timeout_flag and power_down_flag.
// (R3) Undervoltage reset in fast/slow mode keeps both flags.
// (R4) Watchdog reset in fast/slow mode sets timeout_flag, keeps power_down_flag.
// (R5) Power-on reset forces program counter to zero.
// (R6) Power-on reset clears all interrupt enables.
// (R7) Power-on reset clears watchdog and time bases; watchdog restarts.
// (R8) Power-on reset switches every timer module off.
// (R9) Power-on reset makes every port pin an input.
// (R10) Power-on reset points stack pointer at stack top.
// (R11) Each register loads its per-cause value; unchanged kept, unimplemented zero.
// (R12) Active cause is a clock-synchronous one-hot selector sent to registers.
// ----------------------------------------------------------------------------
package reset_state_pkg;

  // Reset cause selector, one-hot.
  typedef enum logic [4:0] {
    CAUSE_NONE      = 5'b00001,
    CAUSE_POWER_ON  = 5'b00010,
    CAUSE_UNDERVOLT = 5'b00100,
    CAUSE_WDT_RUN   = 5'b01000,
    CAUSE_WDT_SLEEP = 5'b10000
  } reset_cause_e;

  // Per-register reset action.
  typedef enum logic [1:0] {
    ACT_KEEP   = 2'h0,
    ACT_LOAD   = 2'h1,
    ACT_UNKNOWN = 2'h2
  } reset_act_e;

  // Status flags held by this block.
  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
  } status_flags_s;

  // Core and peripheral reset commands, one pulse wide.
  typedef struct packed {
    logic clear_pc;
    logic init_stack;
    logic clear_int_enables;
    logic clear_wdt_timebase;
    logic timers_off;
    logic ports_input;
  } reset_cmd_s;

  localparam logic [0:0] FLAG_CLEAR = 1'h0;
  localparam logic [0:0] FLAG_SET = 1'h1;
  localparam int PC_WIDTH = 13;
  localparam int SP_WIDTH = 3;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [2:0] SP_ZERO = 3'h0;
  localparam logic [2:0] SP_TOP = 3'h0;
  localparam int NUM_REGS = 4;
  localparam int REG_WIDTH = 8;

endpackage : reset_state_pkg

// >>> bench/reset_state_distribution_props.sv
// Checker that watches the reset cause decoder from its ports.
`timescale 1ns/10ps
module reset_state_distribution_props
  import reset_state_pkg::*;
#(
  parameter int NREGS = NUM_REGS,
  parameter int RW = REG_WIDTH
)
(
  // Clock, reset and requests.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic power_on_i,
  input wire logic undervoltage_reset_i,
  input wire logic watchdog_timer_timeout_i,
  input wire logic low_power_mode_i,
  // Outputs under watch.
  input wire reset_cause_e cause_o,
  input wire status_flags_s flags_o,
  input wire reset_cmd_s cmd_o,
  input wire logic clear_pc_sp_o,
  input wire logic [NREGS*RW-1:0] regs_o
);
  // Undervoltage counts only in the running modes.
  wire logic uv_run = undervoltage_reset_i && !low_power_mode_i;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // Full resets pulse every command one cycle after their cause.
  sequence s_full;
    cause_o inside {CAUSE_POWER_ON, CAUSE_UNDERVOLT, CAUSE_WDT_RUN};
  endsequence
  sequence s_all_cmds;
    cmd_o == '1 && !clear_pc_sp_o;
  endsequence
  property p_por;
    power_on_i |=> cause_o == CAUSE_POWER_ON;
  endproperty
  property p_uv;
    !power_on_i && uv_run |=> cause_o == CAUSE_UNDERVOLT;
  endproperty
  property p_wr;
    !power_on_i && !undervoltage_reset_i && watchdog_timer_timeout_i &&
      !low_power_mode_i |=> cause_o == CAUSE_WDT_RUN;
  endproperty
  property p_ws;
    !power_on_i && watchdog_timer_timeout_i && low_power_mode_i
      |=> cause_o == CAUSE_WDT_SLEEP;
  endproperty
  property p_clr;
    cause_o == CAUSE_POWER_ON |=> flags_o == 2'b00;
  endproperty
  property p_keep;
    cause_o == CAUSE_UNDERVOLT |=> $stable(flags_o);
  endproperty
  property p_tmo;
    cause_o == CAUSE_WDT_RUN
      |=> flags_o.timeout_flag && $stable(flags_o.power_down_flag);
  endproperty
  property p_slp;
    cause_o == CAUSE_WDT_SLEEP |=> flags_o == 2'b11 && clear_pc_sp_o &&
      cmd_o == '0 && $stable(regs_o);
  endproperty
  property p_cmd;
    s_full |=> s_all_cmds;
  endproperty
  property p_idle;
    cause_o == CAUSE_NONE |=> cmd_o == '0 && !clear_pc_sp_o;
  endproperty
  a_por: assert property (p_por) else $error("no power-on cause");
  a_uv: assert property (p_uv) else $error("no undervolt cause");
  a_wr: assert property (p_wr) else $error("no run wdt cause");
  a_ws: assert property (p_ws) else $error("no sleep wdt cause");
  a_clr: assert property (p_clr) else $error("flags not cleared");
  a_keep: assert property (p_keep) else $error("flags changed");
  a_tmo: assert property (p_tmo) else $error("timeout flag wrong");
  a_slp: assert property (p_slp) else $error("sleep wdt wrong");
  a_cmd: assert property (p_cmd) else $error("cmd set missing");
  a_idle: assert property (p_idle) else $error("stray cmd pulse");
endmodule : reset_state_distribution_props

// >>> bench/reset_state_distribution_tb.sv
// Self-checking bench for the reset cause decoder.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  compares++; \
  if ((got) !== (ex)) \
  begin \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    error_cnt++; \
  end
module reset_state_distribution_tb;
  import reset_state_pkg::*;
  // Register tables; bits low in IMPL stand for unimplemented bits.
  localparam int W = NUM_REGS * REG_WIDTH;
  localparam logic [W-1:0] IMPL = 32'h7FFF_3FFF;
  localparam logic [W-1:0] VPOR = 32'hA5C3_0F1E;
  localparam logic [W-1:0] VUV = 32'h5A3C_F0E1;
  localparam logic [W-1:0] VWR = 32'hC3A5_1E0F;
  // All inputs idle at time zero, reset held.
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic power_on_i = 1'b0;
  logic undervoltage_reset_i = 1'b0;
  logic watchdog_timer_timeout_i = 1'b0;
  logic low_power_mode_i = 1'b0;
  logic flags_we_i = 1'b0;
  logic [NUM_REGS-1:0] reg_we_i = 4'h0;
  logic [REG_WIDTH-1:0] reg_wdata_i = 8'h00;
  status_flags_s flags_wdata_i = 2'h0;
  reset_cause_e cause_o;
  status_flags_s flags_o, ef;
  reset_cmd_s cmd_o;
  logic clear_pc_sp_o;
  logic [W-1:0] regs_o, er;
  logic [3:0] rq;
  logic [3:0] wq;
  int seed = 32'hf120bb69;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  reset_state_distribution #(
    .VAL_POR(VPOR), .VAL_UV(VUV), .VAL_WR(VWR), .IMPL_MASK(IMPL)
  ) u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_on_i(power_on_i),
    .undervoltage_reset_i(undervoltage_reset_i),
    .watchdog_timer_timeout_i(watchdog_timer_timeout_i),
    .low_power_mode_i(low_power_mode_i), .reg_we_i(reg_we_i),
    .reg_wdata_i(reg_wdata_i), .flags_we_i(flags_we_i),
    .flags_wdata_i(flags_wdata_i), .cause_o(cause_o), .flags_o(flags_o),
    .cmd_o(cmd_o), .clear_pc_sp_o(clear_pc_sp_o), .regs_o(regs_o)
  );
  // One request cycle, then wait out the two-cycle answer; r holds
  // {power_on, undervolt, watchdog, low_power}.
  task automatic pulse(input logic [3:0] r, input logic [3:0] we);
    @(posedge sys_clk_i);
    {power_on_i, undervoltage_reset_i, watchdog_timer_timeout_i} <= r[3:1];
    low_power_mode_i <= r[0];
    reg_we_i <= we;
    flags_we_i <= |we;
    reg_wdata_i <= 8'($random(seed));
    flags_wdata_i <= 2'($random(seed));
    @(posedge sys_clk_i);
    {power_on_i, undervoltage_reset_i, watchdog_timer_timeout_i} <= 3'h0;
    reg_we_i <= 4'h0;
    flags_we_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : pulse
  // Model of flags and registers; writes and causes never share a cycle.
  function automatic void expect_next(input logic [3:0] r,
                                      input logic [3:0] we);
    for (int i = 0; i < NUM_REGS; i++)
      if (we[i])
        er[i*8 +: 8] = reg_wdata_i & IMPL[i*8 +: 8];
    if (|we)
      ef = flags_wdata_i;
    if (r[3])
    begin
      ef = 2'b00;
      er = VPOR & IMPL;
    end
    else if (r[2] && !r[0])
      er = VUV & IMPL;
    else if (r[1] && !r[0])
    begin
      ef.timeout_flag = 1'b1;
      er = VWR & IMPL;
    end
    else if (r[1])
      ef = 2'b11;
  endfunction : expect_next
  task automatic compare_all;
    `CHK("flags", ef, flags_o)
    `CHK("regs", er, regs_o)
    `CHK("cause", CAUSE_NONE, cause_o)
  endtask : compare_all
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // Every request code first, then random mixes of writes and requests.
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    ef = 2'b00;
    er = VPOR & IMPL;
    repeat (3) @(posedge sys_clk_i);
    #1;
    compare_all();
    for (int n = 0; n < 64; n++)
    begin
      rq = (n < 16) ? n[3:0] : 4'($random(seed));
      // Keep the strobes, since the task has lowered them by now.
      wq = (n < 16) ? 4'h1 << n[1:0] : 4'($random(seed));
      pulse(4'h0, wq);
      expect_next(4'h0, wq);
      pulse(rq, 4'h0);
      expect_next(rq, 4'h0);
      compare_all();
    end
    end_sim();
  end
  // Hang guard: running out counts as a mismatch.
  initial
  begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule : reset_state_distribution_tb
bind reset_state_distribution reset_state_distribution_props #(
  .NREGS(NREGS), .RW(RW)
) u_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_on_i(power_on_i),
  .undervoltage_reset_i(undervoltage_reset_i),
  .watchdog_timer_timeout_i(watchdog_timer_timeout_i),
  .low_power_mode_i(low_power_mode_i), .cause_o(cause_o),
  .flags_o(flags_o), .cmd_o(cmd_o), .clear_pc_sp_o(clear_pc_sp_o),
  .regs_o(regs_o)
);
